// File: core/ptc_core.sv
// Pulse (tap) event configuration, source status and interrupt logic.
// Assumes an AXI4-Lite master on one clock and synchronous axis samples.
//
// Notes on behaviour
// - With double abort clear, a pulse in the latency window keeps double detection.
// - With double abort set, a whole pulse inside latency suspends double detection.
// - Config bit 6 chooses whether source flags latch.
// - Config bits 5, 3, 1 enable double events for Z, Y, X.
// - Config bits 4, 2, 0 enable single events for Z, Y, X.
// - An event shows only when its axis and type are both enabled.
// - Source bit 7 sets once any enabled pulse event occurs.
// - Source bits 6, 5, 4 mark events on Z, Y, X.
// - Source bit 3 is zero for single, one for double.
// - Source bits 2, 1, 0 give Z, Y, X polarity; one is negative.
// - With latching on, status bits freeze once event active sets, until read.
// - Reading the source register clears all its bits.
// - Reading the source register also drops the pulse interrupt.
// - Configuration and source registers reset to zero.
// - Latency window starts after the first pulse; pulses in it raise no event.
// - Per-axis thresholds are seven-bit unsigned and start pulse detection.
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
module ptc_core
  import ptc_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic [2:0]        awprot,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic [2:0]        arprot,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [DATA_W-1:0]      rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              sample_tick,
  input  wire logic [7:0]        sample_x,
  input  wire logic [7:0]        sample_y,
  input  wire logic [7:0]        sample_z,
  output logic                   tap_irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0]          config_reg;
  logic [6:0]          thr_reg [NUM_AXES];
  logic [7:0]          time_limit_reg;
  logic [7:0]          latency_reg;
  logic [1:0]          irq_enable_reg;
  logic [1:0]          irq_status_reg;
  logic                event_active_reg;
  logic [NUM_AXES-1:0] axis_event_reg;
  logic                double_flag_reg;
  logic [NUM_AXES-1:0] sign_reg;

  logic                aw_hold_reg;
  logic [7:0]          aw_index_reg;
  logic                w_hold_reg;
  logic [7:0]          wdata_reg;
  logic                wlane_reg;

  logic [7:0]          samples [NUM_AXES];
  logic [NUM_AXES-1:0] single_hit;
  logic [NUM_AXES-1:0] double_hit;
  logic [NUM_AXES-1:0] hit_sign;
  logic [NUM_AXES-1:0] single_en;
  logic [NUM_AXES-1:0] double_en;
  logic [NUM_AXES-1:0] single_seen;
  logic [NUM_AXES-1:0] double_seen;
  logic [NUM_AXES-1:0] axis_seen;
  logic [NUM_AXES-1:0] sign_seen;
  logic                any_event;
  logic                frozen;

  logic                do_write;
  logic                write_ok;
  logic                read_take;
  logic [7:0]          read_index;
  logic                source_read;
  logic [7:0]          source_value;
  logic [7:0]          read_value;
  logic                read_ok;

  assign samples[0] = sample_x;
  assign samples[1] = sample_y;
  assign samples[2] = sample_z;

  // ----------------------------------------------------------------
  // Per-axis detectors and event qualification
  // ----------------------------------------------------------------
  for (genvar a = 0; a < NUM_AXES; a++) begin : g_axis
    ptc_axis_detector u_detector (
      .aclk         (aclk),
      .aresetn      (aresetn),
      .sample_tick  (sample_tick),
      .sample       (samples[a]),
      .threshold    (thr_reg[a]),
      .time_limit   (time_limit_reg),
      .latency      (latency_reg),
      .double_abort (config_reg[CFG_DOUBLE_ABORT]),
      .single_hit   (single_hit[a]),
      .double_hit   (double_hit[a]),
      .hit_sign     (hit_sign[a])
    );

    assign single_en[a]   = config_reg[CFG_AXIS_STRIDE*a + CFG_SINGLE_LSB];
    assign double_en[a]   = config_reg[CFG_AXIS_STRIDE*a + CFG_DOUBLE_LSB];
    assign single_seen[a] = single_hit[a] & single_en[a];
    assign double_seen[a] = double_hit[a] & double_en[a];
    assign axis_seen[a]   = single_seen[a] | double_seen[a];
    assign sign_seen[a]   = axis_seen[a] & hit_sign[a];
  end

  assign any_event = |axis_seen;
  // Once frozen, newer pulses are dropped; software loses them until it reads.
  assign frozen    = event_active_reg & config_reg[CFG_LATCH_ENABLE];

  // ----------------------------------------------------------------
  // Source register
  // ----------------------------------------------------------------
  assign source_value = {event_active_reg, axis_event_reg, double_flag_reg, sign_reg};

  // The clear of a read comes first so that an event in the same cycle survives.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      event_active_reg <= 1'b0;
      axis_event_reg   <= '0;
      double_flag_reg  <= 1'b0;
      sign_reg         <= '0;
    end else begin
      if (source_read) begin
        event_active_reg <= 1'b0;
        axis_event_reg   <= '0;
        double_flag_reg  <= 1'b0;
        sign_reg         <= '0;
      end
      if (any_event) begin
        event_active_reg <= 1'b1;
        if (!frozen || source_read) begin
          axis_event_reg  <= axis_seen;
          double_flag_reg <= |double_seen;
          sign_reg        <= sign_seen;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status, enable and output
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_reg <= 2'h0;
    end else begin
      logic [1:0] clr_mask;
      clr_mask = 2'h0;
      if (do_write && wlane_reg && aw_index_reg == IDX_IRQ_CLEAR) begin
        clr_mask = wdata_reg[1:0];
      end
      if (source_read) begin
        clr_mask = 2'h3;
      end
      irq_status_reg[IRQ_SINGLE] <= (irq_status_reg[IRQ_SINGLE] & ~clr_mask[IRQ_SINGLE])
                                    | (|single_seen);
      irq_status_reg[IRQ_DOUBLE] <= (irq_status_reg[IRQ_DOUBLE] & ~clr_mask[IRQ_DOUBLE])
                                    | (|double_seen);
    end
  end

  assign tap_irq = |(irq_status_reg & irq_enable_reg);

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  assign awready  = !aw_hold_reg && !bvalid;
  assign wready   = !w_hold_reg && !bvalid;
  assign do_write = aw_hold_reg && w_hold_reg && !bvalid;

  always_comb begin
    unique case (aw_index_reg)
      IDX_CONFIG, IDX_SOURCE, IDX_THR_X, IDX_THR_Y, IDX_THR_Z,
      IDX_TIME_LIMIT, IDX_LATENCY, IDX_IRQ_STATUS, IDX_IRQ_ENABLE,
      IDX_IRQ_CLEAR: write_ok = 1'b1;
      default:       write_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg  <= 1'b0;
      aw_index_reg <= 8'h00;
    end else if (awvalid && awready) begin
      aw_hold_reg  <= 1'b1;
      aw_index_reg <= awaddr[ADDR_W-1:2];
    end else if (do_write) begin
      aw_hold_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_reg <= 1'b0;
      wdata_reg  <= 8'h00;
      wlane_reg  <= 1'b0;
    end else if (wvalid && wready) begin
      w_hold_reg <= 1'b1;
      wdata_reg  <= wdata[7:0];
      wlane_reg  <= wstrb[0];
    end else if (do_write) begin
      w_hold_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp  <= write_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Only byte lane 0 carries data; writes without it change nothing.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      config_reg     <= CONFIG_RESET;
      time_limit_reg <= TIMER_RESET;
      latency_reg    <= TIMER_RESET;
      irq_enable_reg <= IRQ_EN_RESET;
      thr_reg[0]     <= THR_RESET;
      thr_reg[1]     <= THR_RESET;
      thr_reg[2]     <= THR_RESET;
    end else if (do_write && wlane_reg) begin
      unique case (aw_index_reg)
        IDX_CONFIG:     config_reg     <= wdata_reg;
        IDX_THR_X:      thr_reg[0]     <= wdata_reg[6:0];
        IDX_THR_Y:      thr_reg[1]     <= wdata_reg[6:0];
        IDX_THR_Z:      thr_reg[2]     <= wdata_reg[6:0];
        IDX_TIME_LIMIT: time_limit_reg <= wdata_reg;
        IDX_LATENCY:    latency_reg    <= wdata_reg;
        IDX_IRQ_ENABLE: irq_enable_reg <= wdata_reg[1:0];
        default:        config_reg     <= config_reg;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  assign arready     = !rvalid;
  assign read_take   = arvalid && arready;
  assign read_index  = araddr[ADDR_W-1:2];
  assign source_read = read_take && read_index == IDX_SOURCE;

  always_comb begin
    read_value = 8'h00;
    read_ok    = 1'b1;
    unique case (read_index)
      IDX_CONFIG:     read_value = config_reg;
      IDX_SOURCE:     read_value = source_value;
      IDX_THR_X:      read_value = {1'b0, thr_reg[0]};
      IDX_THR_Y:      read_value = {1'b0, thr_reg[1]};
      IDX_THR_Z:      read_value = {1'b0, thr_reg[2]};
      IDX_TIME_LIMIT: read_value = time_limit_reg;
      IDX_LATENCY:    read_value = latency_reg;
      IDX_IRQ_STATUS: read_value = {6'h00, irq_status_reg};
      IDX_IRQ_ENABLE: read_value = {6'h00, irq_enable_reg};
      IDX_IRQ_CLEAR:  read_value = 8'h00;
      default:        read_ok    = 1'b0;
    endcase
  end

  // The value returned is the one before the read's own clear takes effect.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= RESP_OKAY;
    end else if (read_take) begin
      rvalid <= 1'b1;
      rdata  <= {24'h000000, read_value};
      rresp  <= read_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule // ptc_core

// File: core/ptc_pkg.sv
// Package for the pulse (tap) event configuration and status block.
// Assumes a 32-bit AXI4-Lite register bus and 8-bit signed axis samples.
package ptc_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W   = 10;
  localparam int DATA_W   = 32;
  localparam int NUM_AXES = 3;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_CONFIG     = 8'h21;
  localparam logic [7:0] IDX_SOURCE     = 8'h22;
  localparam logic [7:0] IDX_THR_X      = 8'h23;
  localparam logic [7:0] IDX_THR_Y      = 8'h24;
  localparam logic [7:0] IDX_THR_Z      = 8'h25;
  localparam logic [7:0] IDX_TIME_LIMIT = 8'h26;
  localparam logic [7:0] IDX_LATENCY    = 8'h27;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h30;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'h31;
  localparam logic [7:0] IDX_IRQ_CLEAR  = 8'h32;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CFG_DOUBLE_ABORT = 7;
  localparam int CFG_LATCH_ENABLE = 6;
  localparam int CFG_SINGLE_LSB   = 0;
  localparam int CFG_DOUBLE_LSB   = 1;
  localparam int CFG_AXIS_STRIDE  = 2;
  localparam int SRC_EVENT_ACTIVE = 7;
  localparam int SRC_AXIS_LSB     = 4;
  localparam int SRC_DOUBLE_FLAG  = 3;
  localparam int SRC_SIGN_LSB     = 0;
  localparam int IRQ_SINGLE       = 0;
  localparam int IRQ_DOUBLE       = 1;

  // ----------------------------------------------------------------
  // Reset values and bus answers
  // ----------------------------------------------------------------
  localparam logic [7:0] CONFIG_RESET  = 8'h00;
  localparam logic [6:0] THR_RESET     = 7'h00;
  localparam logic [7:0] TIMER_RESET   = 8'h00;
  localparam logic [1:0] IRQ_EN_RESET  = 2'h0;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

  // ----------------------------------------------------------------
  // Per-axis pulse sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    TAP_IDLE,
    TAP_FIRST,
    TAP_LATENCY,
    TAP_SECOND_WAIT,
    TAP_SECOND,
    TAP_TOO_LONG
  } ptc_tap_state_type;

endpackage

// File: core/ptc_axis_detector.sv
// Per-axis pulse sequencer: finds single and double pulses in one axis.
// Assumes sample_tick is a one-cycle strobe at the output data rate.
`timescale 1ns/1ps
module ptc_axis_detector
  import ptc_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       sample_tick,
  input  wire logic [7:0] sample,
  input  wire logic [6:0] threshold,
  input  wire logic [7:0] time_limit,
  input  wire logic [7:0] latency,
  input  wire logic       double_abort,
  output logic            single_hit,
  output logic            double_hit,
  output logic            hit_sign
);

  ptc_tap_state_type state_reg;
  logic [7:0]        count_reg;
  logic              lat_pulse_reg;
  logic              suspend_reg;
  logic [7:0]        magnitude;
  logic              above;

  // ----------------------------------------------------------------
  // Threshold compare
  // ----------------------------------------------------------------
  assign magnitude = sample[7] ? 8'(-sample) : sample;
  assign above     = magnitude > {1'b0, threshold};

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg     <= TAP_IDLE;
      count_reg     <= TIMER_RESET;
      lat_pulse_reg <= 1'b0;
      suspend_reg   <= 1'b0;
      single_hit    <= 1'b0;
      double_hit    <= 1'b0;
      hit_sign      <= 1'b0;
    end else begin
      single_hit <= 1'b0;
      double_hit <= 1'b0;
      if (sample_tick) begin
        unique case (state_reg)
          TAP_IDLE: begin
            if (above) begin
              state_reg <= TAP_FIRST;
              count_reg <= 8'h00;
              hit_sign  <= sample[7];
            end
          end
          TAP_FIRST: begin
            if (!above) begin
              single_hit    <= 1'b1;
              state_reg     <= TAP_LATENCY;
              count_reg     <= 8'h00;
              lat_pulse_reg <= 1'b0;
              suspend_reg   <= 1'b0;
            end else if (count_reg >= time_limit) begin
              state_reg <= TAP_TOO_LONG;
            end else begin
              count_reg <= count_reg + 8'h01;
            end
          end
          TAP_LATENCY: begin
            // Pulses in this window raise no event; they only feed the abort check.
            if (above) begin
              lat_pulse_reg <= 1'b1;
            end else if (lat_pulse_reg && double_abort) begin
              suspend_reg <= 1'b1;
            end
            if (count_reg >= latency) begin
              count_reg <= 8'h00;
              if (suspend_reg) begin
                state_reg <= above ? TAP_TOO_LONG : TAP_IDLE;
              end else begin
                state_reg <= TAP_SECOND_WAIT;
              end
            end else begin
              count_reg <= count_reg + 8'h01;
            end
          end
          TAP_SECOND_WAIT: begin
            if (above) begin
              state_reg <= TAP_SECOND;
              count_reg <= 8'h00;
              hit_sign  <= sample[7];
            end else if (count_reg >= latency) begin
              state_reg <= TAP_IDLE;
            end else begin
              count_reg <= count_reg + 8'h01;
            end
          end
          TAP_SECOND: begin
            if (!above) begin
              double_hit <= 1'b1;
              state_reg  <= TAP_IDLE;
            end else if (count_reg >= time_limit) begin
              state_reg <= TAP_TOO_LONG;
            end else begin
              count_reg <= count_reg + 8'h01;
            end
          end
          TAP_TOO_LONG: begin
            if (!above) begin
              state_reg <= TAP_IDLE;
            end
          end
          default: begin
            state_reg <= TAP_IDLE;
          end
        endcase
      end
    end
  end

endmodule // ptc_axis_detector

// File: tb/ptc_host.sv
// Host model: an AXI4-Lite master that reads and writes the pulse registers.
// Assumes one clock; the bench bounds every wait with its own timeout.
`timescale 1ns/1ps
module ptc_host
  import ptc_pkg::*;
(
  input  wire logic              aclk,
  output logic [ADDR_W-1:0]      awaddr,
  output logic                   awvalid,
  input  wire logic              awready,
  output logic [DATA_W-1:0]      wdata,
  output logic [3:0]             wstrb,
  output logic                   wvalid,
  input  wire logic              wready,
  input  wire logic [1:0]        bresp,
  input  wire logic              bvalid,
  output logic                   bready,
  output logic [ADDR_W-1:0]      araddr,
  output logic                   arvalid,
  input  wire logic              arready,
  input  wire logic [DATA_W-1:0] rdata,
  input  wire logic [1:0]        rresp,
  input  wire logic              rvalid,
  output logic                   rready
);
  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  initial begin
    {awaddr, awvalid, wdata, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
    wstrb = 4'hF;
  end

  // Address and data go out together; each drops only at its own taking edge.
  task automatic wr(input logic [7:0] idx, input logic [7:0] val, output logic [1:0] resp);
    @(posedge aclk);
    awaddr  <= {idx, 2'b00};
    wdata   <= {24'h000000, val};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    do @(posedge aclk); while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] idx, output logic [7:0] val, output logic [1:0] resp);
    @(posedge aclk);
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    val = rdata[7:0];
    resp = rresp;
    rready <= 1'b0;
  endtask
endmodule // ptc_host

// File: tb/ptc_core_props.sv
// Checker for the pulse block's bus answers and interrupt line.
// Assumes it is bound to ptc_core and sees only its ports.
`timescale 1ns/1ps
module ptc_core_props
  import ptc_pkg::*;
(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              awvalid,
  input wire logic              awready,
  input wire logic              wvalid,
  input wire logic              wready,
  input wire logic [1:0]        bresp,
  input wire logic              bvalid,
  input wire logic              bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic              arvalid,
  input wire logic              arready,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic [1:0]        rresp,
  input wire logic              rvalid,
  input wire logic              rready,
  input wire logic              tap_irq
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_src_read;
    arvalid && arready && araddr[9:2] == IDX_SOURCE;
  endsequence
  sequence s_both_taken;
    awvalid && awready && wvalid && wready;
  endsequence

  AST_RESET_IDLE: assert property ($rose(aresetn) |-> !tap_irq && !bvalid && !rvalid)
    else $error("bus or interrupt active after reset");
  AST_RD_ANSWER: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  AST_RD_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read answer dropped early");
  AST_WR_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped early");
  AST_AR_BLOCK: assert property (rvalid |-> !arready)
    else $error("read taken while answer pending");
  AST_WR_ANSWER: assert property (s_both_taken |=> !bvalid ##1 bvalid)
    else $error("write answer timing wrong");
  AST_RD_UPPER: assert property (rvalid |-> rdata[31:8] == '0)
    else $error("upper read bits not zero");
  AST_RD_UNMAPPED: assert property (arvalid && arready
      && !(araddr[9:2] inside {[IDX_CONFIG:IDX_LATENCY], [IDX_IRQ_STATUS:IDX_IRQ_CLEAR]})
      |=> rresp == RESP_SLVERR && rdata == '0)
    else $error("unmapped read not refused");
  AST_SRC_DROPS_IRQ: assert property (s_src_read |=> !tap_irq)
    else $error("interrupt kept after source read");
  AST_IRQ_FALL: assert property ($fell(tap_irq) |-> bvalid || $past(!aresetn)
      || $past(arvalid && arready && araddr[9:2] == IDX_SOURCE))
    else $error("interrupt fell without a read or write");
endmodule // ptc_core_props

bind ptc_core ptc_core_props ptc_core_props_inst (.*);

// File: tb/test_pulse_event_config_status.sv
// Bench for the pulse event block: host model on the bus, samples from here.
// Assumes ptc_core, ptc_host and the bound checker are compiled before it.
`timescale 1ns/1ps
module test_pulse_event_config_status
  import ptc_pkg::*;
  ();
  // ----------------------------------------------------------------
  // Signals, instances and helpers
  // ----------------------------------------------------------------
  logic              aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready, sample_tick, tap_irq;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp;
  logic [7:0]        sample_x, sample_y, sample_z;
  int                err_total, tests_run, cyc;

  ptc_core ptc_core_inst (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .sample_tick(sample_tick), .sample_x(sample_x), .sample_y(sample_y),
    .sample_z(sample_z), .tap_irq(tap_irq));
  ptc_host ptc_host_inst (.*);

  always #12.5 aclk = ~aclk;

  task automatic stop_test;
    $display("Counts: %0d checks, %0d mismatches", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // The whole run needs a few hundred cycles; this ceiling only catches a hang.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total = err_total + 1;
      stop_test;
    end
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rdc(input string what, input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] v;
    logic [1:0] r;
    ptc_host_inst.rd(idx, v, r);
    chk(what, exp, v);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] val);
    logic [1:0] r;
    ptc_host_inst.wr(idx, val, r);
  endtask

  task automatic tick(input logic [7:0] x, input logic [7:0] y, input logic [7:0] z);
    @(posedge aclk);
    sample_x <= x;
    sample_y <= y;
    sample_z <= z;
    sample_tick <= 1'b1;
    @(posedge aclk);
    sample_tick <= 1'b0;
  endtask

  task automatic quiet(input int n);
    repeat (n) tick(8'h00, 8'h00, 8'h00);
  endtask

  // Source bits land two edges after the closing tick; four gives margin.
  task automatic pulse(input logic [7:0] x, input logic [7:0] y, input logic [7:0] z);
    tick(x, y, z);
    tick(8'h00, 8'h00, 8'h00);
    repeat (4) @(posedge aclk);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    logic [7:0] v;
    logic [1:0] r;
    rdc("config reset", IDX_CONFIG, 8'h00);
    rdc("source reset", IDX_SOURCE, 8'h00);
    chk("irq reset", 8'h00, {7'h00, tap_irq});
    ptc_host_inst.rd(8'h40, v, r);
    chk("unmapped resp", {6'h00, RESP_SLVERR}, {6'h00, r});
    wr(IDX_SOURCE, 8'hFF);
    rdc("source write ignored", IDX_SOURCE, 8'h00);
    wr(IDX_CONFIG, 8'hFF);
    rdc("config readback", IDX_CONFIG, 8'hFF);
    wr(IDX_THR_X, 8'hFF);
    rdc("threshold width", IDX_THR_X, 8'h7F);
    $display("test reset done");
  endtask

  // Each axis alone enabled; all three pulse negative, only that axis shows.
  task automatic t_axes;
    logic [7:0] e;
    for (int a = 0; a < 3; a++) begin
      e = 8'h80 | 8'(8'h10 << a) | 8'(8'h01 << a);
      wr(IDX_CONFIG, 8'(8'h01 << (2 * a)));
      pulse(8'hEC, 8'hEC, 8'hEC);
      chk("irq set", 8'h01, {7'h00, tap_irq});
      rdc("source axis", IDX_SOURCE, e);
      rdc("source cleared", IDX_SOURCE, 8'h00);
      chk("irq cleared", 8'h00, {7'h00, tap_irq});
      quiet(12);
    end
    $display("test axes done");
  endtask

  // A whole pulse sits inside the latency window, a second one follows it.
  task automatic t_double(input logic abort, input logic [7:0] exp);
    wr(IDX_CONFIG, {abort, 7'h02});
    pulse(8'h14, 8'h00, 8'h00);
    quiet(1);
    tick(8'h14, 8'h00, 8'h00);
    quiet(3);
    pulse(8'h14, 8'h00, 8'h00);
    rdc("source double", IDX_SOURCE, exp);
    rdc("source cleared", IDX_SOURCE, 8'h00);
    quiet(12);
    $display("test double done");
  endtask

  task automatic t_latch(input logic le, input logic [7:0] exp);
    wr(IDX_CONFIG, {1'b0, le, 6'h05});
    pulse(8'h14, 8'h00, 8'h00);
    pulse(8'h00, 8'hEC, 8'h00);
    rdc("source latch", IDX_SOURCE, exp);
    rdc("source cleared", IDX_SOURCE, 8'h00);
    quiet(12);
    $display("test latch done");
  endtask

  task automatic t_irq;
    wr(IDX_CONFIG, 8'h01);
    pulse(8'h14, 8'h00, 8'h00);
    rdc("irq status", IDX_IRQ_STATUS, 8'h01);
    wr(IDX_IRQ_CLEAR, 8'h01);
    chk("irq after clear", 8'h00, {7'h00, tap_irq});
    rdc("active kept", IDX_SOURCE, 8'h90);
    wr(IDX_IRQ_ENABLE, 8'h00);
    quiet(12);
    pulse(8'h14, 8'h00, 8'h00);
    chk("irq masked", 8'h00, {7'h00, tap_irq});
    rdc("source masked", IDX_SOURCE, 8'h90);
    $display("test irq done");
  endtask

  initial begin
    {aclk, aresetn, sample_tick, sample_x, sample_y, sample_z} = '0;
    {err_total, tests_run, cyc} = '0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    wr(IDX_THR_X, 8'h0A);
    wr(IDX_THR_Y, 8'h0A);
    wr(IDX_THR_Z, 8'h0A);
    wr(IDX_TIME_LIMIT, 8'h04);
    wr(IDX_LATENCY, 8'h03);
    wr(IDX_IRQ_ENABLE, 8'h03);
    t_axes;
    t_double(1'b0, 8'h98);
    t_double(1'b1, 8'h00);
    t_latch(1'b1, 8'h90);
    t_latch(1'b0, 8'hA2);
    t_irq;
    stop_test;
  end
endmodule // test_pulse_event_config_status
